// ### rtl/clock_source_pll_control.sv
// Clock source selection, PLL control, clock gating and start-up timing
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module clock_source_pll_control #(
    parameter int TOUT_LONG = clk_ctrl_pkg::TOUT_LONG_CYC,
    parameter int WAKE_XT = clk_ctrl_pkg::WAKE_XT_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fuses
    input wire logic [3:0] clock_source_select_fuses_i,
    input wire logic [1:0] startup_time_fuses_i,
    input wire logic initial_divide_by_eight_fuse_i,
    input wire logic pll_system_clock_fuse_i,
    // Oscillator ticks from pins or other domains
    input wire logic wdog_osc_tick_i,
    input wire logic src_osc_tick_i,
    // Sleep request from core
    input wire logic sleep_req_i,
    input wire logic wake_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Clock controls
    output logic rc_osc_on_o,
    output logic pll_on_o,
    output logic [3:0] pll_mult_o,
    output logic [7:0] rc_trim_o,
    output logic rc_compat_trim_o,
    output logic pll_saturated_o,
    output logic [3:0] sys_src_o,
    output logic sys_div8_o,
    output logic core_clk_en_o,
    output logic io_clk_en_o,
    output logic flash_clk_en_o,
    output logic adc_clk_en_o,
    output logic async_irq_en_o,
    output logic timer2_fast_clk_sel_o,
    output logic [2:0] timer2_fast_prescale_o,
    output logic reset_tout_busy_o
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] wdog_sync_r;
    logic [1:0] src_sync_r;
    logic wdog_prev_r;
    logic src_prev_r;
    logic wdog_edge;
    logic src_edge;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdog_sync_r <= 2'h0;
            src_sync_r <= 2'h0;
            wdog_prev_r <= 1'b0;
            src_prev_r <= 1'b0;
        end else begin
            wdog_sync_r <= {wdog_sync_r[0], wdog_osc_tick_i};
            src_sync_r <= {src_sync_r[0], src_osc_tick_i};
            wdog_prev_r <= wdog_sync_r[1];
            src_prev_r <= src_sync_r[1];
        end
    end
    assign wdog_edge = wdog_sync_r[1] & ~wdog_prev_r;
    assign src_edge = src_sync_r[1] & ~src_prev_r;

    // ----------------------------------------
    // Fuse capture after reset
    // ----------------------------------------
    clk_ctrl_pkg::sm_e state_r;
    logic [13:0] tout_cnt_r;
    logic [3:0] src_r;
    logic [1:0] sut_r;
    logic div8_r;
    logic pll_system_clock_fuse_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_r <= clk_ctrl_pkg::DEF_SRC_SEL; // RQ11
            sut_r <= clk_ctrl_pkg::DEF_SUT; // RQ11
            div8_r <= clk_ctrl_pkg::DEF_DIV8; // RQ11
            pll_system_clock_fuse_r <= 1'b1;
        end else if (state_r == clk_ctrl_pkg::SM_RESET_TOUT && tout_cnt_r == 14'h0) begin
            src_r <= clock_source_select_fuses_i;
            sut_r <= startup_time_fuses_i;
            div8_r <= initial_divide_by_eight_fuse_i;
            pll_system_clock_fuse_r <= pll_system_clock_fuse_i;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic pll_en_r;
    logic [7:0] trim_r;
    logic [2:0] slp_mode_r;
    logic t2_sel_r;
    logic [2:0] t2_pre_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic lock_r;
    logic wr_stb;
    assign wr_stb = cyc_i & stb_i & we_i & ~ack_r & sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_en_r <= 1'b0;
            trim_r <= clk_ctrl_pkg::RC_TRIM_RST;
            slp_mode_r <= 3'h0;
            t2_sel_r <= 1'b0;
            t2_pre_r <= 3'h0;
        end else if (wr_stb) begin
            case (adr_i)
                clk_ctrl_pkg::PLL_CSR_OFS: begin
                    pll_en_r <= dat_i[clk_ctrl_pkg::PLL_EN_BIT];
                    t2_sel_r <= dat_i[2];
                    t2_pre_r <= dat_i[6:4];
                end
                clk_ctrl_pkg::RC_TRIM_OFS: trim_r <= dat_i[7:0];
                clk_ctrl_pkg::SLEEP_OFS: slp_mode_r <= dat_i[2:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= cyc_i & stb_i & ~ack_r;
            case (adr_i)
                clk_ctrl_pkg::PLL_CSR_OFS: dat_r <= {25'h0, t2_pre_r, 1'b0, t2_sel_r,
                                                    pll_en_r, lock_r};
                clk_ctrl_pkg::RC_TRIM_OFS: dat_r <= {24'h0, trim_r};
                clk_ctrl_pkg::SLEEP_OFS: dat_r <= {29'h0, slp_mode_r};
                clk_ctrl_pkg::STATUS_OFS: dat_r <= {20'h0, src_r, 2'h0, sut_r,
                                                   div8_r, pll_system_clock_fuse_r, state_r[1:0]};
                default: dat_r <= 32'h0;
            endcase
        end
    end
    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ----------------------------------------
    // Start-up state machine
    // ----------------------------------------
    logic [14:0] wake_cnt_r;
    logic [14:0] tout_len;
    logic [14:0] wake_len;
    logic deep_sleep;
    logic rc_src;
    assign rc_src = src_r == clk_ctrl_pkg::SRC_RC8 || src_r == clk_ctrl_pkg::SRC_RC64;
    assign tout_len = (sut_r == 2'h0) ? 15'h0 :
                      (sut_r == 2'h1) ? 15'(clk_ctrl_pkg::TOUT_SHORT_CYC) :
                      15'(TOUT_LONG); // RQ10
    assign wake_len = rc_src ? 15'(clk_ctrl_pkg::WAKE_RC_CYC) : 15'(WAKE_XT);
    assign deep_sleep = state_r == clk_ctrl_pkg::SM_SLEEP &&
                        (slp_mode_r == clk_ctrl_pkg::SLP_PDOWN ||
                         slp_mode_r == clk_ctrl_pkg::SLP_STBY);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= clk_ctrl_pkg::SM_RESET_TOUT;
            tout_cnt_r <= 14'h0;
            wake_cnt_r <= 15'h0;
        end else begin
            case (state_r)
                clk_ctrl_pkg::SM_RESET_TOUT: begin
                    if (tout_cnt_r != 14'h0 && {1'b0, tout_cnt_r} > tout_len) begin
                        state_r <= clk_ctrl_pkg::SM_RUN; // RQ9
                    end else if (wdog_edge || tout_cnt_r == 14'h0) begin
                        tout_cnt_r <= tout_cnt_r + 14'h1; // RQ9
                    end
                end
                clk_ctrl_pkg::SM_RUN: begin
                    if (sleep_req_i) begin
                        state_r <= clk_ctrl_pkg::SM_SLEEP; // RQ12
                    end
                end
                clk_ctrl_pkg::SM_SLEEP: begin
                    if (wake_i) begin
                        wake_cnt_r <= 15'h0;
                        state_r <= (slp_mode_r == clk_ctrl_pkg::SLP_PDOWN ||
                                    slp_mode_r == clk_ctrl_pkg::SLP_PSAVE) ?
                                   clk_ctrl_pkg::SM_WAKE : clk_ctrl_pkg::SM_RUN;
                    end
                end
                clk_ctrl_pkg::SM_WAKE: begin
                    if (wake_cnt_r >= wake_len) begin
                        state_r <= clk_ctrl_pkg::SM_RUN; // RQ8
                    end else if (src_edge) begin
                        wake_cnt_r <= wake_cnt_r + 15'h1; // RQ8
                    end
                end
                default: state_r <= clk_ctrl_pkg::SM_RESET_TOUT;
            endcase
        end
    end

    // ----------------------------------------
    // PLL control and lock
    // ----------------------------------------
    logic pll_run;
    logic [7:0] lock_cnt_r;
    logic over_nominal;
    assign over_nominal = trim_r > clk_ctrl_pkg::RC_TRIM_NOMINAL;
    assign pll_run = (pll_en_r | ~pll_system_clock_fuse_r) & ~deep_sleep; // RQ3 RQ5
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_cnt_r <= 8'h0;
            lock_r <= 1'b0;
        end else if (!pll_run || over_nominal) begin
            lock_cnt_r <= 8'h0; // RQ16
            lock_r <= 1'b0; // RQ19
        end else if (lock_cnt_r >= 8'(clk_ctrl_pkg::LOCK_CYC)) begin
            lock_r <= 1'b1; // RQ4
        end else begin
            lock_cnt_r <= lock_cnt_r + 8'h1;
        end
    end
    assign pll_on_o = pll_run;
    assign rc_osc_on_o = ~deep_sleep; // RQ5
    assign pll_mult_o = (src_r == clk_ctrl_pkg::SRC_RC64) ? clk_ctrl_pkg::MULT_COMPAT :
                        clk_ctrl_pkg::MULT_NORMAL; // RQ1 RQ2
    assign rc_compat_trim_o = src_r == clk_ctrl_pkg::SRC_RC64; // RQ2
    assign rc_trim_o = trim_r; // RQ16
    assign pll_saturated_o = pll_run & over_nominal; // RQ16
    assign sys_src_o = src_r; // RQ7
    assign sys_div8_o = ~div8_r; // RQ18
    assign timer2_fast_clk_sel_o = t2_sel_r & lock_r; // RQ6
    assign timer2_fast_prescale_o = t2_pre_r; // RQ6

    // ----------------------------------------
    // Clock gating
    // ----------------------------------------
    logic running;
    assign running = state_r == clk_ctrl_pkg::SM_RUN;
    assign core_clk_en_o = running; // RQ12
    assign flash_clk_en_o = running; // RQ14
    assign io_clk_en_o = running || state_r == clk_ctrl_pkg::SM_SLEEP &&
                         slp_mode_r == clk_ctrl_pkg::SLP_IDLE; // RQ13
    assign adc_clk_en_o = running || state_r == clk_ctrl_pkg::SM_SLEEP &&
                          slp_mode_r <= clk_ctrl_pkg::SLP_ADC; // RQ15
    assign async_irq_en_o = 1'b1; // RQ13
    assign reset_tout_busy_o = state_r == clk_ctrl_pkg::SM_RESET_TOUT;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    pll_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        pll_on_o == ((pll_en_r | ~pll_system_clock_fuse_r) & ~deep_sleep)) else $error("pll gate");
    lock_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        !pll_run |=> !lock_r) else $error("lock while off");
    lock_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
        (pll_run && !over_nominal)[*8] ##1 (pll_run && !over_nominal)[*8] ##1
        (pll_run && !over_nominal)[*8] ##1 (pll_run && !over_nominal)[*8] |-> lock_r)
        else $error("no lock");
    deep_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
        deep_sleep |-> !rc_osc_on_o && !pll_on_o) else $error("osc on in sleep");
    mult_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
        pll_mult_o == (rc_compat_trim_o ? 4'h4 : 4'h8)) else $error("mult");
    flash_core_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
        flash_clk_en_o == core_clk_en_o) else $error("flash gate");
    sat_lock_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16
        over_nominal |=> !lock_r) else $error("lock above nominal");
    core_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
        $rose(state_r == clk_ctrl_pkg::SM_SLEEP) |-> !core_clk_en_o) else $error("core");
    adc_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ15
        state_r == clk_ctrl_pkg::SM_SLEEP && slp_mode_r == clk_ctrl_pkg::SLP_ADC |->
        adc_clk_en_o && !io_clk_en_o) else $error("adc gate");
    wake_c: cover property (@(posedge clk_i) state_r == clk_ctrl_pkg::SM_WAKE ##1
        state_r == clk_ctrl_pkg::SM_RUN);
    lock_c: cover property (@(posedge clk_i) $rose(lock_r));
    tout_c: cover property (@(posedge clk_i) $fell(reset_tout_busy_o));
endmodule

// ### rtl/clk_ctrl_pkg.sv
// Package with constants for the clock source and PLL control block
// Notes on behaviour
// RQ1: Normal mode: PLL multiplies the 8.0 MHz RC clock by eight to 64 MHz.
// RQ2: Select 0011 trims RC to 6.4 MHz and PLL multiplies by four.
// RQ3: PLL runs only if software enable is set or PLL clock fuse is zero.
// RQ4: Lock flag sets once the PLL has locked to its reference.
// RQ5: RC oscillator and PLL are off in power-down and standby.
// RQ6: Fast clock, direct or prescaled, is a clock source for timer two.
// RQ7: Four-bit source select decodes to the listed sources; programmed fuse reads zero.
// RQ8: Wake from power-down or power-save is timed on the selected source.
// RQ9: Start from reset adds a real-time delay counted on the watchdog oscillator.
// RQ10: Reset time-out counts 512 cycles for 4 ms, 8192 for 64 ms.
// RQ11: Factory default: select 0010, start-up 10, divide-by-eight programmed.
// RQ12: Core clock gate stops core logic; sleep modes halt unused clocks.
// RQ13: I/O clock drives peripherals; async interrupt detection works while halted.
// RQ14: Flash clock is enabled together with the core clock.
// RQ15: Converter clock keeps running while core and I/O clocks stop.
// RQ16: PLL follows RC trim; above nominal it saturates and loses lock.
// RQ17: Software should keep the RC trim at or below nominal.
// RQ18: Divide-by-eight fuse prescales the system clock by eight from start-up.
// RQ19: Lock flag reads zero when the PLL is disabled or asleep.
package clk_ctrl_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] PLL_CSR_OFS = 4'h0;
    localparam logic [3:0] RC_TRIM_OFS = 4'h4;
    localparam logic [3:0] SLEEP_OFS = 4'h8;
    localparam logic [3:0] STATUS_OFS = 4'hc;
    localparam int PLL_EN_BIT = 1;
    localparam int PLL_LOCK_BIT = 0;
    localparam logic [7:0] RC_TRIM_RST = 8'h80;
    localparam logic [7:0] RC_TRIM_NOMINAL = 8'h80;
    // ----------------------------------------
    // Source select codes
    // ----------------------------------------
    localparam logic [3:0] SRC_EXT = 4'h0;
    localparam logic [3:0] SRC_PLL = 4'h1;
    localparam logic [3:0] SRC_RC8 = 4'h2;
    localparam logic [3:0] SRC_RC64 = 4'h3;
    localparam logic [3:0] SRC_WDOG = 4'h4;
    localparam logic [3:0] SRC_LFXT = 4'h6;
    localparam logic [3:0] DEF_SRC_SEL = 4'h2;
    localparam logic [1:0] DEF_SUT = 2'h2;
    localparam logic DEF_DIV8 = 1'b0;
    localparam logic [3:0] MULT_NORMAL = 4'h8;
    localparam logic [3:0] MULT_COMPAT = 4'h4;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int TOUT_SHORT_CYC = 512;
    localparam int TOUT_LONG_CYC = 8192;
    localparam int WAKE_RC_CYC = 6;
    localparam int WAKE_XT_CYC = 16384;
    localparam int LOCK_NS = 100;
    localparam int CLK_PERIOD_NS = 4;
    localparam int LOCK_CYC = (LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SM_RESET_TOUT = 3'b000,
        SM_RUN = 3'b001,
        SM_SLEEP = 3'b010,
        SM_WAKE = 3'b011
    } sm_e;
    typedef enum logic [2:0] {
        SLP_IDLE = 3'b000,
        SLP_ADC = 3'b001,
        SLP_PDOWN = 3'b010,
        SLP_PSAVE = 3'b011,
        SLP_STBY = 3'b110
    } slp_e;
endpackage

// ### verif/osc_source_model.sv
// Oscillator sources that the clock block counts
`timescale 1ns/1ps
module osc_source_model #(
    parameter int WDOG_HALF = 4,
    parameter int SRC_HALF = 2
) (
    // Clock
    input wire logic clk_i,
    // Oscillator square waves
    output logic wdog_osc_tick_o,
    output logic src_osc_tick_o
);
    int wcnt = 0;
    int scnt = 0;
    initial begin
        wdog_osc_tick_o = 1'b0;
        src_osc_tick_o = 1'b0;
    end
    // Watchdog oscillator, period 2*WDOG_HALF cycles
    always @(posedge clk_i) begin
        wcnt <= (wcnt == WDOG_HALF - 1) ? 0 : wcnt + 1;
        if (wcnt == WDOG_HALF - 1) begin
            wdog_osc_tick_o <= ~wdog_osc_tick_o;
        end
    end
    // Selected source oscillator, period 2*SRC_HALF cycles
    always @(posedge clk_i) begin
        scnt <= (scnt == SRC_HALF - 1) ? 0 : scnt + 1;
        if (scnt == SRC_HALF - 1) begin
            src_osc_tick_o <= ~src_osc_tick_o;
        end
    end
endmodule

// ### verif/clock_source_pll_control_bench.sv
// Self-checking bench for the clock source and PLL control block
`timescale 1ns/1ps
module clock_source_pll_control_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] fsel = 4'h2;
    logic [1:0] fsut = 2'h2;
    logic fdiv8 = 1'b0;
    logic fpll = 1'b1;
    logic sleep_req_i = 1'b0;
    logic wake_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, rc_osc_on_o, pll_on_o, rc_compat_trim_o, pll_saturated_o, sys_div8_o;
    logic core_clk_en_o, io_clk_en_o, flash_clk_en_o, adc_clk_en_o, async_irq_en_o;
    logic timer2_fast_clk_sel_o, reset_tout_busy_o, wdog_tick, src_tick;
    logic [3:0] pll_mult_o, sys_src_o;
    logic [7:0] rc_trim_o;
    logic [2:0] timer2_fast_prescale_o;
    int mismatches = 0;
    int comparisons = 0;
    int seed = 32'h7236;
    // ----------------------------------------
    // Design and oscillators
    // ----------------------------------------
    clock_source_pll_control #(.TOUT_LONG(16), .WAKE_XT(8)) u_clock_source_pll_control (
        .clk_i(clk_i), .rst_i(rst_i), .clock_source_select_fuses_i(fsel),
        .startup_time_fuses_i(fsut), .initial_divide_by_eight_fuse_i(fdiv8),
        .pll_system_clock_fuse_i(fpll), .wdog_osc_tick_i(wdog_tick), .src_osc_tick_i(src_tick),
        .sleep_req_i(sleep_req_i), .wake_i(wake_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rc_osc_on_o(rc_osc_on_o), .pll_on_o(pll_on_o), .pll_mult_o(pll_mult_o),
        .rc_trim_o(rc_trim_o), .rc_compat_trim_o(rc_compat_trim_o),
        .pll_saturated_o(pll_saturated_o), .sys_src_o(sys_src_o), .sys_div8_o(sys_div8_o),
        .core_clk_en_o(core_clk_en_o), .io_clk_en_o(io_clk_en_o),
        .flash_clk_en_o(flash_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
        .async_irq_en_o(async_irq_en_o), .timer2_fast_clk_sel_o(timer2_fast_clk_sel_o),
        .timer2_fast_prescale_o(timer2_fast_prescale_o), .reset_tout_busy_o(reset_tout_busy_o));
    osc_source_model u_osc_source_model (
        .clk_i(clk_i), .wdog_osc_tick_o(wdog_tick), .src_osc_tick_o(src_tick));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // Tasks and expectations
    // ----------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 100);
        q = dat_o;
        chk("ack", 1, ack_o);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic d8,
                            input logic pf, output int busy);
        @(posedge clk_i);
        fsel <= s;
        fsut <= t;
        fdiv8 <= d8;
        fpll <= pf;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        busy = 0;
        repeat (2) @(posedge clk_i);
        while (reset_tout_busy_o === 1'b1 && busy < 10000) begin
            @(posedge clk_i);
            busy++;
        end
        @(posedge clk_i);
        chk("core_after_reset", 1, core_clk_en_o);
    endtask
    function automatic logic [31:0] stat_exp(input logic [3:0] s, input logic [1:0] t,
                                             input logic d8, input logic pf);
        return {20'h0, s, 2'b00, t, d8, pf, 2'b01};
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int b;
        int k;
        int m;
        logic [31:0] q;
        logic [7:0] v;
        logic [2:0] p;
        repeat (3) @(posedge clk_i);
        for (k = 0; k < 16; k++) begin
            do_reset(k[3:0], 2'b00, k[0], k[1], b);
            chk("busy_none", 1, b <= 2);
            chk("src", k[3:0], sys_src_o);
            chk("compat", k == 3, rc_compat_trim_o);
            chk("mult", (k == 3) ? 4'h4 : 4'h8, pll_mult_o);
            chk("div8", !k[0], sys_div8_o);
            chk("pll_fuse_on", !k[1], pll_on_o);
            wb(1'b0, 4'hc, 32'h0, 4'hf, q);
            chk("status", stat_exp(k[3:0], 2'b00, k[0], k[1]), q);
        end
        do_reset(4'h2, 2'b01, 1'b0, 1'b1, b);
        chk("tout_short", 1, b > 512 * 8 - 16 && b < 512 * 8 + 16);
        do_reset(4'h2, 2'b11, 1'b1, 1'b1, b);
        chk("tout_sut3", 1, b > 16 * 8 - 16 && b < 16 * 8 + 16);
        do_reset(4'h2, 2'b10, 1'b0, 1'b1, b);
        chk("tout_long", 1, b > 16 * 8 - 16 && b < 16 * 8 + 16);
        chk("div8_default", 1, sys_div8_o);
        chk("pll_off", 0, pll_on_o);
        chk("run_gates", 4'hf, {core_clk_en_o, io_clk_en_o, flash_clk_en_o, adc_clk_en_o});
        wb(1'b1, 4'h0, 32'h2, 4'h1, q);
        chk("pll_on", 1, pll_on_o);
        wb(1'b0, 4'h0, 32'h0, 4'hf, q);
        chk("lock_early", 32'h2, q);
        repeat (40) @(posedge clk_i);
        wb(1'b0, 4'h0, 32'h0, 4'hf, q);
        chk("locked", 32'h3, q);
        for (k = 0; k < 5; k++) begin
            v = (k == 0) ? 8'h80 : 8'($random(seed)) & 8'h7f;
            wb(1'b1, 4'h4, {24'h0, v}, 4'h1, q);
            wb(1'b0, 4'h4, 32'h0, 4'hf, q);
            chk("trim", {24'h0, v}, q);
            chk("trim_out", v, rc_trim_o);
            chk("no_sat", 0, pll_saturated_o);
        end
        wb(1'b1, 4'h4, 32'h90, 4'h1, q);
        chk("sat", 1, pll_saturated_o);
        wb(1'b0, 4'h0, 32'h0, 4'hf, q);
        chk("lock_lost", 32'h2, q);
        wb(1'b1, 4'h4, 32'h80, 4'h1, q);
        wb(1'b1, 4'h4, 32'h11, 4'he, q);
        wb(1'b0, 4'h4, 32'h0, 4'hf, q);
        chk("sel_ignored", 32'h80, q);
        wb(1'b1, 4'h1, 32'hff, 4'hf, q);
        wb(1'b0, 4'h1, 32'h0, 4'hf, q);
        chk("unmapped", 32'h0, q);
        repeat (40) @(posedge clk_i);
        p = 3'($random(seed));
        wb(1'b1, 4'h0, {25'h0, p, 4'b0110}, 4'h1, q);
        chk("t2_sel", 1, timer2_fast_clk_sel_o);
        chk("t2_pre", p, timer2_fast_prescale_o);
        for (k = 0; k < 5; k++) begin
            m = (k == 4) ? 6 : k;
            wb(1'b1, 4'h8, m, 4'h1, q);
            @(posedge clk_i);
            sleep_req_i <= 1'b1;
            @(posedge clk_i);
            sleep_req_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk("core_off", 0, core_clk_en_o);
            chk("flash_core", core_clk_en_o, flash_clk_en_o);
            chk("io", m == 0, io_clk_en_o);
            chk("adc", m <= 1, adc_clk_en_o);
            chk("rc_on", m != 2 && m != 6, rc_osc_on_o);
            chk("pll_sleep", m != 2 && m != 6, pll_on_o);
            chk("async", 1, async_irq_en_o);
            if (m == 2) begin
                wb(1'b0, 4'h0, 32'h0, 4'hf, q);
                chk("lock_sleep", 0, q[0]);
            end
            @(posedge clk_i);
            wake_i <= 1'b1;
            @(posedge clk_i);
            wake_i <= 1'b0;
            b = 0;
            while (core_clk_en_o !== 1'b1 && b < 200) begin
                @(posedge clk_i);
                b++;
            end
            chk("wake", 1, (m == 2 || m == 3) ? (b >= 6 * 4 - 8 && b <= 6 * 4 + 8) : (b <= 4));
        end
        wb(1'b1, 4'h0, 32'h0, 4'h1, q);
        chk("pll_dis", 0, pll_on_o);
        wb(1'b0, 4'h0, 32'h0, 4'hf, q);
        chk("lock_off", 0, q[0]);
        chk("t2_off", 0, timer2_fast_clk_sel_o);
        summarize();
    end
    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        summarize();
    end
endmodule
